// [hdl/bdu_top.sv]
`timescale 1ns/1ns
// Functional notes
// - four address registers compared on every cycle
// - reserved numbers alias status/control when extensions off
// - reserved numbers raise undefined opcode when extensions on
// - all matching breakpoints flagged when an enabled one hits, only enabled ones trap
// - guarded debug register access flags and faults first
// - step flag traps after each retired instruction
// - task switch with trap flag sets flag, traps
// - local arms enable; cleared on every task switch
// - global arms enable, survive task switch, override local
// - legacy exact bits stored but inert
// - guard enables access fault; cleared on any exception
// - type field selects exec, write, io, read/write
// - size field selects one, two, four bytes
// - data, io, step, task events trap on vector 01h
// - exec breakpoints and guard hits fault on vector 01h
// - opcode CCh traps on vector 03h after completion
module bdu_top
   import bdu_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        cyc_valid,
   input  wire logic [31:0] cyc_addr,
   input  wire logic [1:0]  cyc_kind,
   input  wire logic [1:0]  cyc_len,
   input  wire logic        insn_retire,
   input  wire logic [7:0]  insn_opcode,
   input  wire logic        step_flag,
   input  wire logic        task_switch,
   input  wire logic        task_trap_flag,
   input  wire logic        ext_dbg_enable,
   input  wire logic        dr_req,
   input  wire logic        dr_write,
   input  wire logic [2:0]  dr_num,
   input  wire logic [31:0] dr_wdata,
   output logic [31:0]      dr_rdata,
   output logic             dr_done,
   output logic             exc_valid,
   output logic [7:0]       exc_vector,
   output logic             exc_fault,
   output logic             ud_fault
);
   logic [31:0]           bp_addr_q [BDU_NUM_BP];
   logic [31:0]           bp_addr_d [BDU_NUM_BP];
   logic [31:0]           sts_q;
   logic [31:0]           sts_d;
   logic [31:0]           ctl_q;
   logic [31:0]           ctl_d;
   logic                  pend_q;
   logic                  pend_d;
   logic [31:0]           rdata_q;
   logic [31:0]           rdata_d;
   logic                  done_q;
   logic                  done_d;
   logic                  exc_q;
   logic                  exc_d;
   logic [7:0]            vec_q;
   logic [7:0]            vec_d;
   logic                  fault_q;
   logic                  fault_d;
   logic                  ud_q;
   logic                  ud_d;
   logic [BDU_NUM_BP-1:0] bp_hit;
   logic [BDU_NUM_BP-1:0] bp_en;
   logic [BDU_NUM_BP-1:0] bp_exec;
   logic                  any_en_hit;
   logic                  exec_flt;
   logic                  data_hit;
   logic                  step_trap;
   logic                  task_trap;
   logic                  bkpt_trap;
   logic                  dbg_trap;
   logic                  any_exc;
   logic                  wr_go;

   bdu_acc_if acc ();

   assign acc.req    = dr_req;
   assign acc.write  = dr_write;
   assign acc.num    = dr_num;
   assign acc.ext_en = ext_dbg_enable;
   assign acc.guard  = ctl_q[BDU_CTL_GUARD_BIT];

   bdu_access u_access (
      .acc (acc)
   );

   for (genvar i = 0; i < BDU_NUM_BP; i++) begin : g_bp
      localparam int unsigned FB = BDU_CTL_FIELD_BASE +
                                   BDU_CTL_FIELD_STRIDE * i;
      localparam int unsigned AB = BDU_CTL_ARM_STRIDE * i;
      // global arm overrides a cleared local arm
      assign bp_en[i] = ctl_q[AB] ||
                        ctl_q[AB + BDU_CTL_GLOBAL_OFS];
      assign bp_exec[i] = (ctl_q[FB +: 2] == BDU_RW_EXEC);
      bdu_match u_match (
         .bp_addr   (bp_addr_q[i]),
         .bp_rw     (ctl_q[FB +: 2]),
         .bp_len    (ctl_q[FB + BDU_CTL_LEN_OFS +: 2]),
         .ext_en    (ext_dbg_enable),
         .cyc_valid (cyc_valid),
         .cyc_addr  (cyc_addr),
         .cyc_kind  (cyc_kind),
         .cyc_len   (cyc_len),
         .hit       (bp_hit[i])
      );
   end

   assign any_en_hit = |(bp_hit & bp_en);
   assign exec_flt   = |(bp_hit & bp_en & bp_exec);
   assign data_hit   = |(bp_hit & bp_en & ~bp_exec);
   assign step_trap  = insn_retire && step_flag;
   assign task_trap  = task_switch && task_trap_flag;
   assign bkpt_trap  = insn_retire && (insn_opcode == BDU_OPC_BKPT);
   // data hits of the retiring instruction still belong to it
   assign dbg_trap   = step_trap || task_trap ||
                       (insn_retire && (pend_q || data_hit));
   assign any_exc    = acc.guard_hit || exec_flt || dbg_trap || bkpt_trap;
   assign wr_go      = acc.go && dr_write;

   always_comb begin
      pend_d = insn_retire ? 1'b0 : (pend_q || data_hit);
   end

   always_comb begin
      for (int k = 0; k < BDU_NUM_BP; k++) begin
         bp_addr_d[k] = bp_addr_q[k];
         if (wr_go && acc.target == 3'(k)) begin
            bp_addr_d[k] = dr_wdata;
         end
      end
   end

   // hardware sets are applied after the software write: set wins
   always_comb begin
      sts_d = sts_q;
      if (wr_go && acc.target == BDU_REG_STATUS) begin
         sts_d = dr_wdata & BDU_STATUS_MASK;
      end
      if (any_en_hit) begin
         sts_d[BDU_NUM_BP-1:0] = sts_d[BDU_NUM_BP-1:0] | bp_hit;
      end
      if (acc.guard_hit) begin
         sts_d[BDU_STS_REGACC_BIT] = 1'b1;
      end
      if (step_trap) begin
         sts_d[BDU_STS_STEP_BIT] = 1'b1;
      end
      if (task_trap) begin
         sts_d[BDU_STS_TASK_BIT] = 1'b1;
      end
   end

   // exact bits are kept by the mask and read by nothing else
   always_comb begin
      ctl_d = ctl_q;
      if (wr_go && acc.target == BDU_REG_CONTROL) begin
         ctl_d = dr_wdata & BDU_CONTROL_MASK;
      end
      if (task_switch) begin
         ctl_d = ctl_d & ~BDU_CTL_LOCAL_MASK;
      end
      if (any_exc) begin
         ctl_d[BDU_CTL_GUARD_BIT] = 1'b0;
      end
   end

   always_comb begin
      rdata_d = rdata_q;
      done_d  = acc.go;
      if (acc.go && !dr_write) begin
         unique case (acc.target)
            BDU_REG_STATUS:  rdata_d = sts_q;
            BDU_REG_CONTROL: rdata_d = ctl_q;
            default: begin
               if (acc.target <= BDU_REG_ADDR_LAST) begin
                  rdata_d = bp_addr_q[acc.target[1:0]];
               end
            end
         endcase
      end
   end

   // one exception per cycle: faults before traps, vector 01h first
   always_comb begin
      exc_d   = any_exc;
      ud_d    = acc.ud;
      vec_d   = BDU_VEC_DEBUG;
      fault_d = acc.guard_hit || exec_flt;
      if (!acc.guard_hit && !exec_flt && !dbg_trap && bkpt_trap) begin
         vec_d = BDU_VEC_BKPT;
      end
      if (!any_exc) begin
         vec_d = vec_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int k = 0; k < BDU_NUM_BP; k++) begin
            bp_addr_q[k] <= BDU_ADDR_RST;
         end
         sts_q   <= BDU_STATUS_RST;
         ctl_q   <= BDU_CONTROL_RST;
         pend_q  <= 1'b0;
         rdata_q <= BDU_ADDR_RST;
         done_q  <= 1'b0;
         exc_q   <= 1'b0;
         vec_q   <= BDU_VEC_RST;
         fault_q <= 1'b0;
         ud_q    <= 1'b0;
      end else begin
         for (int k = 0; k < BDU_NUM_BP; k++) begin
            bp_addr_q[k] <= bp_addr_d[k];
         end
         sts_q   <= sts_d;
         ctl_q   <= ctl_d;
         pend_q  <= pend_d;
         rdata_q <= rdata_d;
         done_q  <= done_d;
         exc_q   <= exc_d;
         vec_q   <= vec_d;
         fault_q <= fault_d;
         ud_q    <= ud_d;
      end
   end

   assign dr_rdata   = rdata_q;
   assign dr_done    = done_q;
   assign exc_valid  = exc_q;
   assign exc_vector = vec_q;
   assign exc_fault  = fault_q;
   assign ud_fault   = ud_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_guarded_req;
      dr_req && ctl_q[BDU_CTL_GUARD_BIT];
   endsequence

   sequence s_dbg_fault;
      exc_valid && exc_fault && exc_vector == BDU_VEC_DEBUG;
   endsequence

   sequence s_dbg_trap;
      exc_valid && !exc_fault && exc_vector == BDU_VEC_DEBUG;
   endsequence

   chk_guard_fault: assert property (
      s_guarded_req |=> s_dbg_fault ##0
         (sts_q[BDU_STS_REGACC_BIT] && !dr_done))
      else $error("guarded access did not fault first");

   chk_guard_clear: assert property (
      exc_valid |-> !ctl_q[BDU_CTL_GUARD_BIT])
      else $error("guard still set after exception");

   chk_alias_undef: assert property (
      dr_req && ext_dbg_enable && !ctl_q[BDU_CTL_GUARD_BIT] &&
      (dr_num == BDU_REG_ALIAS_LO || dr_num == BDU_REG_ALIAS_HI)
      |=> ud_fault && !dr_done)
      else $error("reserved number access not refused");

   chk_alias_write: assert property (
      dr_req && dr_write && !ext_dbg_enable && !task_switch &&
      !ctl_q[BDU_CTL_GUARD_BIT] && dr_num == BDU_REG_ALIAS_HI &&
      !exec_flt && !dbg_trap && !bkpt_trap
      |=> ctl_q == ($past(dr_wdata) & BDU_CONTROL_MASK))
      else $error("alias write did not reach control");

   chk_step_trap: assert property (
      step_trap && !acc.guard_hit && !exec_flt
      |=> s_dbg_trap ##0 sts_q[BDU_STS_STEP_BIT])
      else $error("single step trap missing");

   chk_task_trap: assert property (
      task_trap && !acc.guard_hit && !exec_flt
      |=> s_dbg_trap ##0 sts_q[BDU_STS_TASK_BIT])
      else $error("task switch trap missing");

   chk_local_clear: assert property (
      task_switch |=> (ctl_q & BDU_CTL_LOCAL_MASK) == 32'h0000_0000)
      else $error("local arms survived task switch");

   chk_global_keep: assert property (
      task_switch && !wr_go
      |=> (ctl_q & BDU_CTL_GLOBAL_MASK) ==
          ($past(ctl_q) & BDU_CTL_GLOBAL_MASK))
      else $error("global arms lost on task switch");

   chk_exec_fault: assert property (
      exec_flt && !acc.guard_hit |=> s_dbg_fault)
      else $error("exec breakpoint did not fault");

   chk_bkpt_trap: assert property (
      bkpt_trap && !acc.guard_hit && !exec_flt && !dbg_trap
      |=> exc_valid && !exc_fault && exc_vector == BDU_VEC_BKPT)
      else $error("breakpoint opcode trap missing");

   chk_hit_flags: assert property (
      any_en_hit |=> (sts_q[BDU_NUM_BP-1:0] & $past(bp_hit)) ==
                     $past(bp_hit))
      else $error("matching breakpoint flag not set");

   // pending or same-cycle data hit traps when its instruction retires
   chk_data_trap: assert property (
      insn_retire && (pend_q || data_hit) && !acc.guard_hit && !exec_flt
      |=> s_dbg_trap)
      else $error("data breakpoint trap missing");
endmodule

// [hdl/bdu_pkg.sv]
package bdu_pkg;

   localparam int unsigned BDU_NUM_BP = 4;

   // debug register numbers as seen by the move instructions
   localparam logic [2:0] BDU_REG_ADDR_LAST = 3'h3;
   localparam logic [2:0] BDU_REG_ALIAS_LO  = 3'h4;
   localparam logic [2:0] BDU_REG_ALIAS_HI  = 3'h5;
   localparam logic [2:0] BDU_REG_STATUS    = 3'h6;
   localparam logic [2:0] BDU_REG_CONTROL   = 3'h7;

   // breakpoint_status fields
   localparam int unsigned BDU_STS_REGACC_BIT = 13;
   localparam int unsigned BDU_STS_STEP_BIT   = 14;
   localparam int unsigned BDU_STS_TASK_BIT   = 15;
   localparam logic [31:0] BDU_STATUS_MASK    = 32'h0000_e00f;
   localparam logic [31:0] BDU_STATUS_RST     = 32'h0000_0000;

   // breakpoint_control fields
   localparam int unsigned BDU_CTL_ARM_STRIDE   = 2;
   localparam int unsigned BDU_CTL_GLOBAL_OFS   = 1;
   localparam int unsigned BDU_CTL_LEXACT_BIT   = 8;
   localparam int unsigned BDU_CTL_GEXACT_BIT   = 9;
   localparam int unsigned BDU_CTL_GUARD_BIT    = 13;
   localparam int unsigned BDU_CTL_FIELD_BASE   = 16;
   localparam int unsigned BDU_CTL_FIELD_STRIDE = 4;
   localparam int unsigned BDU_CTL_LEN_OFS      = 2;
   localparam logic [31:0] BDU_CTL_LOCAL_MASK   = 32'h0000_0055;
   localparam logic [31:0] BDU_CTL_GLOBAL_MASK  = 32'h0000_00aa;
   localparam logic [31:0] BDU_CONTROL_MASK     = 32'hffff_23ff;
   localparam logic [31:0] BDU_CONTROL_RST      = 32'h0000_0000;
   localparam logic [31:0] BDU_ADDR_RST         = 32'h0000_0000;

   // match type and match size encodings
   localparam logic [1:0] BDU_RW_EXEC  = 2'h0;
   localparam logic [1:0] BDU_RW_WRITE = 2'h1;
   localparam logic [1:0] BDU_RW_IO    = 2'h2;
   localparam logic [1:0] BDU_RW_RDWR  = 2'h3;
   localparam logic [1:0] BDU_LEN_1    = 2'h0;
   localparam logic [1:0] BDU_LEN_2    = 2'h1;
   localparam logic [1:0] BDU_LEN_4    = 2'h3;
   localparam logic [2:0] BDU_SPAN_1   = 3'h1;
   localparam logic [2:0] BDU_SPAN_2   = 3'h2;
   localparam logic [2:0] BDU_SPAN_4   = 3'h4;

   // processor cycle kinds presented by the core
   localparam logic [1:0] BDU_KIND_FETCH = 2'h0;
   localparam logic [1:0] BDU_KIND_WRITE = 2'h1;
   localparam logic [1:0] BDU_KIND_IO    = 2'h2;
   localparam logic [1:0] BDU_KIND_READ  = 2'h3;

   localparam logic [7:0] BDU_VEC_DEBUG = 8'h01;
   localparam logic [7:0] BDU_VEC_BKPT  = 8'h03;
   localparam logic [7:0] BDU_OPC_BKPT  = 8'hcc;
   localparam logic [7:0] BDU_VEC_RST   = 8'h00;

   // undefined size code 10b is treated as one byte
   function automatic logic [2:0] bdu_span(input logic [1:0] len);
      logic [2:0] s;
      s = BDU_SPAN_1;
      if (len == BDU_LEN_2) s = BDU_SPAN_2;
      if (len == BDU_LEN_4) s = BDU_SPAN_4;
      return s;
   endfunction

endpackage

// [hdl/bdu_acc_if.sv]
`timescale 1ns/1ns
interface bdu_acc_if;
   logic       req;
   logic       write;
   logic [2:0] num;
   logic       ext_en;
   logic       guard;
   logic       ud;
   logic       guard_hit;
   logic       go;
   logic [2:0] target;

   modport decoder (
      input  req, write, num, ext_en, guard,
      output ud, guard_hit, go, target
   );
   modport owner (
      output req, write, num, ext_en, guard,
      input  ud, guard_hit, go, target
   );
endinterface

// [hdl/bdu_access.sv]
`timescale 1ns/1ns
module bdu_access
   import bdu_pkg::*;
(
   bdu_acc_if.decoder acc
);
   logic is_alias;

   assign is_alias = (acc.num == BDU_REG_ALIAS_LO) ||
                     (acc.num == BDU_REG_ALIAS_HI);

   // guard is checked first so the debugger sees the access attempt
   assign acc.guard_hit = acc.req && acc.guard;
   assign acc.ud = acc.req && !acc.guard && acc.ext_en
                   && is_alias;
   assign acc.go = acc.req && !acc.guard && !(acc.ext_en && is_alias);

   always_comb begin
      acc.target = acc.num;
      if (!acc.ext_en && acc.num == BDU_REG_ALIAS_LO) begin
         acc.target = BDU_REG_STATUS;
      end
      if (!acc.ext_en && acc.num == BDU_REG_ALIAS_HI) begin
         acc.target = BDU_REG_CONTROL;
      end
   end
endmodule

// [hdl/bdu_match.sv]
`timescale 1ns/1ns
module bdu_match
   import bdu_pkg::*;
(
   input  wire logic [31:0] bp_addr,
   input  wire logic [1:0]  bp_rw,
   input  wire logic [1:0]  bp_len,
   input  wire logic        ext_en,
   input  wire logic        cyc_valid,
   input  wire logic [31:0] cyc_addr,
   input  wire logic [1:0]  cyc_kind,
   input  wire logic [1:0]  cyc_len,
   output logic             hit
);
   logic [32:0] bp_end;
   logic [32:0] cyc_end;
   logic        overlap;
   logic        kind_ok;

   // 33-bit ends so a range at the top of memory does not wrap
   assign bp_end  = {1'b0, bp_addr} + {30'h0, bdu_span(bp_len)};
   assign cyc_end = {1'b0, cyc_addr} + {30'h0, bdu_span(cyc_len)};
   assign overlap = ({1'b0, bp_addr} < cyc_end) &&
                    ({1'b0, cyc_addr} < bp_end);

   always_comb begin
      kind_ok = 1'b0;
      unique case (bp_rw)
         BDU_RW_EXEC:  kind_ok = (cyc_kind == BDU_KIND_FETCH);
         BDU_RW_WRITE: kind_ok = (cyc_kind == BDU_KIND_WRITE);
         // io matching only with extensions on; otherwise undefined
         BDU_RW_IO:    kind_ok = ext_en && (cyc_kind == BDU_KIND_IO);
         BDU_RW_RDWR:  kind_ok = (cyc_kind == BDU_KIND_WRITE) ||
                                 (cyc_kind == BDU_KIND_READ);
      endcase
   end

   assign hit = cyc_valid && kind_ok && overlap;
endmodule

// [test/bdu_tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, exp, act) \
   begin \
      checked++; \
      if ((act) !== (exp)) begin \
         n_errors++; \
         $display("[FAIL] %s expected %h seen %h", nm, exp, act); \
      end \
   end

module bdu_tb_top import bdu_pkg::*;;
   logic        sys_clk;
   logic        rst_n;
   logic        cyc_valid;
   logic [31:0] cyc_addr;
   logic [1:0]  cyc_kind;
   logic [1:0]  cyc_len;
   logic        insn_retire;
   logic [7:0]  insn_opcode;
   logic        step_flag;
   logic        task_switch;
   logic        task_trap_flag;
   logic        ext_dbg_enable;
   logic        dr_req;
   logic        dr_write;
   logic [2:0]  dr_num;
   logic [31:0] dr_wdata;
   logic [31:0] dr_rdata;
   logic        dr_done;
   logic        exc_valid;
   logic [7:0]  exc_vector;
   logic        exc_fault;
   logic        ud_fault;
   logic        o_done;
   logic        o_ud;
   logic        o_exc;
   logic        o_flt;
   logic [7:0]  o_vec;
   logic [31:0] o_rd;
   int          n_errors;
   int          checked;

   bdu_top u_dut (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .cyc_valid      (cyc_valid),
      .cyc_addr       (cyc_addr),
      .cyc_kind       (cyc_kind),
      .cyc_len        (cyc_len),
      .insn_retire    (insn_retire),
      .insn_opcode    (insn_opcode),
      .step_flag      (step_flag),
      .task_switch    (task_switch),
      .task_trap_flag (task_trap_flag),
      .ext_dbg_enable (ext_dbg_enable),
      .dr_req         (dr_req),
      .dr_write       (dr_write),
      .dr_num         (dr_num),
      .dr_wdata       (dr_wdata),
      .dr_rdata       (dr_rdata),
      .dr_done        (dr_done),
      .exc_valid      (exc_valid),
      .exc_vector     (exc_vector),
      .exc_fault      (exc_fault),
      .ud_fault       (ud_fault)
   );

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic end_test(input string nm);
      $display("test %s done, mismatches so far %0d", nm, n_errors);
   endtask

   // every input moves 1 ns after the rising edge
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   // single-cycle outputs are grabbed in the cycle they stand
   task automatic cap();
      tick();
      o_done = dr_done;
      o_ud   = ud_fault;
      o_exc  = exc_valid;
      o_vec  = exc_vector;
      o_flt  = exc_fault;
      o_rd   = dr_rdata;
   endtask

   // idle cycle after each request keeps dr_req from being rewritten
   task automatic acc(input logic wr, input logic [2:0] n,
                      input logic [31:0] d);
      dr_req   = 1'b1;
      dr_write = wr;
      dr_num   = n;
      dr_wdata = d;
      cap();
      dr_req = 1'b0;
      tick();
   endtask

   task automatic wr(input logic [2:0] n, input logic [31:0] d);
      acc(1'b1, n, d);
      `CHK("write done", 1'b1, o_done)
   endtask

   task automatic rd_chk(input logic [2:0] n, input logic [31:0] exp,
                         input string nm);
      acc(1'b0, n, 32'h0);
      `CHK(nm, 1'b1, o_done)
      `CHK(nm, exp, o_rd)
   endtask

   task automatic exc_chk(input logic v, input logic [7:0] vec,
                          input logic flt, input string nm);
      `CHK(nm, v, o_exc)
      if (v) begin
         `CHK(nm, vec, o_vec)
         `CHK(nm, flt, o_flt)
      end
   endtask

   task automatic cyc(input logic [1:0] k, input logic [31:0] a,
                      input logic [1:0] l);
      cyc_valid = 1'b1;
      cyc_kind  = k;
      cyc_addr  = a;
      cyc_len   = l;
      cap();
      cyc_valid = 1'b0;
      tick();
   endtask

   task automatic retire(input logic [7:0] opc);
      insn_retire = 1'b1;
      insn_opcode = opc;
      cap();
      insn_retire = 1'b0;
      tick();
   endtask

   initial begin
      repeat (3000) @(posedge sys_clk);
      n_errors++;
      $display("[FAIL] watchdog expired before the tests ended");
      stop_test();
   end

   initial begin
      n_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      {cyc_valid, insn_retire, step_flag, task_switch} = 4'h0;
      {task_trap_flag, ext_dbg_enable, dr_req, dr_write} = 4'h0;
      cyc_addr = 32'h0;
      cyc_kind = 2'h0;
      cyc_len = 2'h0;
      insn_opcode = 8'h00;
      dr_num = 3'h0;
      dr_wdata = 32'h0;
      repeat (8) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++)
         if (i != 4 && i != 5) rd_chk(i[2:0], 32'h0, "reset value");
      end_test("reset");

      for (int i = 0; i < 4; i++) wr(i[2:0], 32'ha5a5_0000 | i);
      for (int i = 0; i < 4; i++)
         rd_chk(i[2:0], 32'ha5a5_0000 | i, "address reg");
      wr(BDU_REG_CONTROL, 32'hffff_dfff);
      rd_chk(BDU_REG_CONTROL, 32'hffff_03ff, "control");
      wr(BDU_REG_STATUS, 32'hffff_ffff);
      rd_chk(BDU_REG_STATUS, 32'h0000_e00f, "status");
      rd_chk(BDU_REG_ALIAS_LO, 32'h0000_e00f, "alias low");
      rd_chk(BDU_REG_ALIAS_HI, 32'hffff_03ff, "alias high");
      wr(BDU_REG_ALIAS_HI, 32'h0);
      rd_chk(BDU_REG_CONTROL, 32'h0, "alias write");
      end_test("registers");

      ext_dbg_enable = 1'b1;
      acc(1'b0, BDU_REG_ALIAS_LO, 32'h0);
      `CHK("ud on low read", 1'b1, o_ud)
      `CHK("no access low", 1'b0, o_done)
      acc(1'b1, BDU_REG_ALIAS_HI, 32'h1);
      `CHK("ud on high write", 1'b1, o_ud)
      rd_chk(BDU_REG_CONTROL, 32'h0, "control untouched");
      ext_dbg_enable = 1'b0;
      end_test("undefined opcode");

      wr(BDU_REG_STATUS, 32'h0);
      wr(BDU_REG_CONTROL, 32'h0000_2000);
      acc(1'b0, 3'h0, 32'h0);
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b1, "guard fault");
      `CHK("guarded access blocked", 1'b0, o_done)
      rd_chk(BDU_REG_STATUS, 32'h0000_2000, "guard hit flag");
      rd_chk(BDU_REG_CONTROL, 32'h0, "guard cleared");
      end_test("guard");

      wr(3'h0, 32'h0000_1000);
      wr(BDU_REG_STATUS, 32'h0);
      wr(BDU_REG_CONTROL, 32'h0000_0001);
      cyc(BDU_KIND_FETCH, 32'h0000_1001, BDU_LEN_1);
      exc_chk(1'b0, BDU_VEC_DEBUG, 1'b1, "fetch miss");
      cyc(BDU_KIND_FETCH, 32'h0000_1000, BDU_LEN_1);
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b1, "exec fault");
      rd_chk(BDU_REG_STATUS, 32'h0000_0001, "exec flag");
      end_test("exec breakpoint");

      // bp1 four bytes at 2002 armed, bp2 two bytes at 2005 disarmed
      wr(3'h1, 32'h0000_2002);
      wr(3'h2, 32'h0000_2005);
      wr(BDU_REG_STATUS, 32'h0);
      wr(BDU_REG_CONTROL, 32'h05d0_0004);
      cyc(BDU_KIND_WRITE, 32'h0000_2007, BDU_LEN_1);
      exc_chk(1'b0, BDU_VEC_DEBUG, 1'b0, "write miss");
      cyc(BDU_KIND_WRITE, 32'h0000_2004, BDU_LEN_2);
      exc_chk(1'b0, BDU_VEC_DEBUG, 1'b0, "trap waits");
      rd_chk(BDU_REG_STATUS, 32'h0000_0006, "overlap flags");
      retire(8'h90);
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b0, "data trap");
      end_test("data breakpoint");

      // bp0 read/write global, bp3 io global
      ext_dbg_enable = 1'b1;
      wr(3'h3, 32'h0000_0080);
      wr(BDU_REG_STATUS, 32'h0);
      wr(BDU_REG_CONTROL, 32'h2003_0082);
      cyc(BDU_KIND_READ, 32'h0000_1000, BDU_LEN_1);
      cyc(BDU_KIND_IO, 32'h0000_0080, BDU_LEN_1);
      retire(8'h90);
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b0, "io trap");
      rd_chk(BDU_REG_STATUS, 32'h0000_0009, "read io flags");
      ext_dbg_enable = 1'b0;
      end_test("io breakpoint");

      wr(BDU_REG_STATUS, 32'h0);
      wr(BDU_REG_CONTROL, 32'h0000_0009);
      task_switch = 1'b1;
      task_trap_flag = 1'b1;
      cap();
      task_switch = 1'b0;
      task_trap_flag = 1'b0;
      tick();
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b0, "task trap");
      rd_chk(BDU_REG_STATUS, 32'h0000_8000, "task flag");
      rd_chk(BDU_REG_CONTROL, 32'h0000_0008, "arms");
      end_test("task switch");

      wr(BDU_REG_STATUS, 32'h0);
      step_flag = 1'b1;
      retire(8'h90);
      step_flag = 1'b0;
      exc_chk(1'b1, BDU_VEC_DEBUG, 1'b0, "step trap");
      rd_chk(BDU_REG_STATUS, 32'h0000_4000, "step flag");
      end_test("single step");

      // guard armed: a read succeeding afterwards proves it was cleared
      wr(BDU_REG_CONTROL, 32'h0000_2000);
      retire(BDU_OPC_BKPT);
      exc_chk(1'b1, BDU_VEC_BKPT, 1'b0, "breakpoint opcode");
      rd_chk(BDU_REG_CONTROL, 32'h0, "guard cleared");
      end_test("breakpoint opcode");
      stop_test();
   end
endmodule
